/* File: bench/apc_far_end.sv */
// far end model: master clocks, link pin clock and slave port clocks
`timescale 1ns/1ps
`default_nettype none

module apc_far_end (
  input wire logic run_bclk,
  input wire logic run_link,
  output logic mclk_one = 1'b0,
  output logic mclk_two = 1'b0,
  output logic link_clk = 1'b0,
  output logic [2:0] bclk = 3'h0,
  output logic [2:0] lrclk = 3'h0
);
  int bcnt = 0;
  // odd start offsets keep every pin unrelated in phase to clk_sys
  initial begin
    #3;
    forever #20 mclk_one = ~mclk_one;
  end
  initial begin
    #5;
    forever #28 mclk_two = ~mclk_two;
  end
  // everything below derives from master clock one, so all stays in step
  always @(posedge mclk_one) begin
    link_clk <= run_link ? ~link_clk : 1'b0;
    if (!run_bclk) begin
      bclk <= 3'h0;
      lrclk <= 3'h0;
      bcnt <= 0;
    end else begin
      bclk <= ~bclk;
      if (bclk[0]) begin
        bcnt <= (bcnt == 31) ? 0 : bcnt + 1;
        if (bcnt == 31) lrclk <= ~lrclk;
      end
    end
  end
endmodule
`default_nettype wire

/* File: bench/apc_top_checker.sv */
// port assertions for the audio port clock source selection top
`timescale 1ns/1ps
`default_nettype none
`include "apc_cfg.svh"

module apc_top_checker (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [2:0] port_master_mode,
  input wire logic [2:0][3:0] port_rate_code,
  input wire logic [1:0] main_clock_source_select,
  input wire logic [3:0] main_clock_frequency_setting,
  input wire logic [3:0] secondary_clock_frequency_setting,
  input wire logic [2:0] port_bclk_out,
  input wire logic [2:0] port_bclk_oe,
  input wire logic [2:0] port_lrclk_out,
  input wire logic [2:0] port_lrclk_oe,
  input wire logic [2:0] port_on_secondary,
  input wire logic main_system_clock_tick,
  input wire logic secondary_system_clock_tick,
  input wire logic [1:0] ratio_valid
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // quiet counter: cycles since the last system tick
  // ----------------------------------------------------------------
  logic [2:0] sec_want;
  logic [3:0] quiet_reg;
  logic [3:0] quiet_next;
  logic any_tick;
  always_comb begin
    any_tick = main_system_clock_tick | secondary_system_clock_tick;
    for (int i = 0; i < 3; i++) sec_want[i] = port_rate_code[i] >= `APC_RATE_SECONDARY;
    quiet_next = (!rst_n || any_tick) ? 4'h0 : ((quiet_reg == 4'hF) ? quiet_reg : quiet_reg + 4'h1);
  end
  always_ff @(posedge clk_sys) begin
    quiet_reg <= quiet_next;
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_oe_follows_mode: assert property ($past(rst_n, 2) |-> port_bclk_oe == $past(port_master_mode))
    else $error("bit clock enable does not follow master mode");
  a_oe_pair_equal: assert property ($past(rst_n) |-> port_lrclk_oe == port_bclk_oe)
    else $error("frame clock enable differs from bit clock enable");
  a_slave_quiet_out: assert property ($past(rst_n, 2) && !port_bclk_oe[0] && !$past(port_bclk_oe[0])
    |-> !port_bclk_out[0] && !port_lrclk_out[0]) else $error("slave port drives a clock");
  a_rate_select: assert property ($past(rst_n, 2) |-> port_on_secondary == $past(sec_want))
    else $error("port clock choice does not match rate code");
  a_ratio_flag: assert property ($past(rst_n, 2) |-> ratio_valid ==
    $past({secondary_clock_frequency_setting != 4'h0, main_clock_frequency_setting != 4'h0}))
    else $error("ratio flag wrong");
  // a tick already in the output register may still leave, hence the two cycle slack
  a_switch_silence: assert property ($past(rst_n, 2) && $changed(main_clock_source_select)
    |-> ##2 (!main_system_clock_tick) [*3]) else $error("tick during source switch-over");
  a_bclk_tick_sync: assert property ($past(rst_n, 3) && quiet_reg >= 4'h4 && !any_tick
    && $stable(port_bclk_oe) && $past(port_bclk_oe) == $past(port_bclk_oe, 2) |-> $stable(port_bclk_out))
    else $error("bit clock moved without a system tick");
  a_lrclk_align: assert property (port_lrclk_oe[0] && $past(port_lrclk_oe[0]) && $past(rst_n, 2)
    && $changed(port_lrclk_out[0]) |-> !port_bclk_out[0]) else $error("frame clock moved off a falling bit clock");
  c_main_tick: cover property (main_system_clock_tick);
  c_on_secondary: cover property ($rose(port_on_secondary[2]));
  c_switch: cover property ($changed(main_clock_source_select));
endmodule

bind apc_top apc_top_checker u_checker (
  .clk_sys,
  .rst_n,
  .port_master_mode,
  .port_rate_code,
  .main_clock_source_select,
  .main_clock_frequency_setting,
  .secondary_clock_frequency_setting,
  .port_bclk_out,
  .port_bclk_oe,
  .port_lrclk_out,
  .port_lrclk_oe,
  .port_on_secondary,
  .main_system_clock_tick,
  .secondary_system_clock_tick,
  .ratio_valid
);
`default_nettype wire

/* File: bench/apc_top_tb.sv */
// self-checking bench for the clock source selection top
`timescale 1ns/1ps
`default_nettype none
`include "apc_cfg.svh"

module apc_top_tb;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic run_bclk = 1'b0;
  // link clock runs from the start so its domain sees reset; a late start leaves its toggle unknown
  logic run_link = 1'b1;
  logic [2:0] port_master_mode = 3'h0;
  logic [2:0][3:0] port_rate_code = '0;
  logic [1:0] main_clock_source_select = 2'h0;
  logic [1:0] secondary_clock_source_select = 2'h0;
  logic [1:0][3:0] loop_reference_select = '0;
  logic [3:0] main_clock_frequency_setting = 4'h1;
  logic [3:0] secondary_clock_frequency_setting = 4'h1;
  logic [2:0] port_bclk_out, port_bclk_oe, port_lrclk_out, port_lrclk_oe, port_on_secondary;
  logic main_system_clock_tick, secondary_system_clock_tick;
  logic [1:0] loop_locked, ratio_valid;
  wire link_bus_clock_pin, master_clock_input_one, master_clock_input_two;
  wire [2:0] port_bclk_in, port_lrclk_in;
  int n_mismatch = 0;
  int tests_run = 0;

  initial forever #4 clk_sys = ~clk_sys;

  apc_top DUT (.clk_sys, .rst_n, .link_bus_clock_pin, .master_clock_input_one, .master_clock_input_two,
    .port_master_mode, .port_rate_code, .port_bclk_in, .port_lrclk_in, .main_clock_source_select,
    .secondary_clock_source_select, .loop_reference_select, .main_clock_frequency_setting,
    .secondary_clock_frequency_setting, .port_bclk_out, .port_bclk_oe, .port_lrclk_out, .port_lrclk_oe,
    .port_on_secondary, .main_system_clock_tick, .secondary_system_clock_tick, .loop_locked, .ratio_valid);

  apc_far_end u_far (.run_bclk, .run_link, .mclk_one(master_clock_input_one),
    .mclk_two(master_clock_input_two), .link_clk(link_bus_clock_pin), .bclk(port_bclk_in), .lrclk(port_lrclk_in));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expd);
    tests_run++;
    if (seen !== expd) begin
      n_mismatch++;
      $display("ERROR %s expected %0h seen %0h", what, expd, seen);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  function automatic logic [31:0] near(input int a, input int b, input int tol);
    return 32'((a - b <= tol) && (b - a <= tol));
  endfunction
  // counts main ticks, secondary ticks and port 0 bit clock toggles
  task automatic measure(input int n, output int mt, output int st, output int bt);
    logic b;
    mt = 0;
    st = 0;
    bt = 0;
    b = port_bclk_out[0];
    repeat (n) begin
      @(negedge clk_sys);
      mt += int'(main_system_clock_tick);
      st += int'(secondary_system_clock_tick);
      bt += int'(port_bclk_out[0] !== b);
      b = port_bclk_out[0];
    end
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_rate;
    logic [3:0] codes [4] = '{4'h0, 4'h7, 4'h8, 4'hF};
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_sys);
      for (int i = 0; i < 3; i++) port_rate_code[i] <= codes[(k + i) % 4];
      cycles(3);
      for (int i = 0; i < 3; i++) check("on secondary", 32'(port_on_secondary[i]), 32'(codes[(k + i) % 4] >= 4'h8));
    end
  endtask
  task automatic t_master(input logic [3:0] div, input apc_pkg::apc_sys_src_t src, input int exp_ticks);
    int mt, st, bt;
    @(posedge clk_sys);
    port_master_mode <= 3'h5;
    port_rate_code <= '0;
    main_clock_source_select <= src;
    main_clock_frequency_setting <= div;
    cycles(30);
    check("bclk enable", 32'(port_bclk_oe), 32'h0000_0005);
    measure(1400, mt, st, bt);
    check("main ticks", near(mt, exp_ticks, 2), 32'h0000_0001);
    check("bclk toggles", near(bt, mt / int'(div), 2), 32'h0000_0001);
  endtask
  task automatic t_frame;
    int n;
    logic lr, b;
    n = 0;
    lr = port_lrclk_out[0];
    repeat (2000) begin
      @(negedge clk_sys);
      if (port_lrclk_out[0] !== lr) break;
    end
    lr = port_lrclk_out[0];
    b = port_bclk_out[0];
    repeat (2000) begin
      @(negedge clk_sys);
      n += int'(port_bclk_out[0] && !b);
      b = port_bclk_out[0];
      if (port_lrclk_out[0] !== lr) break;
    end
    check("bclk per half frame", 32'(n), 32'h0000_0020);
  endtask
  task automatic t_refuse;
    int mt, st, bt;
    @(posedge clk_sys);
    main_clock_frequency_setting <= 4'h0;
    secondary_clock_frequency_setting <= 4'h0;
    cycles(10);
    check("main ratio flag", 32'(ratio_valid[0]), 32'h0000_0000);
    check("secondary ratio flag", 32'(ratio_valid[1]), 32'h0000_0000);
    measure(200, mt, st, bt);
    check("blocked bclk toggles", 32'(bt), 32'h0000_0000);
    @(posedge clk_sys);
    main_clock_frequency_setting <= 4'h1;
    secondary_clock_frequency_setting <= 4'h1;
    cycles(3);
    check("ratio flags restored", 32'(ratio_valid), 32'h0000_0003);
  endtask
  // reference period 10 cycles, loop times four: 560 ticks in 1400 cycles
  task automatic t_slave_loop;
    int mt, st, bt;
    @(posedge clk_sys);
    port_master_mode <= 3'h0;
    run_bclk <= 1'b1;
    loop_reference_select[0] <= apc_pkg::APC_REF_BCLK_ONE;
    main_clock_source_select <= apc_pkg::APC_SRC_LOOP_ONE;
    cycles(400);
    measure(1400, mt, st, bt);
    check("loop one lock", 32'(loop_locked[0]), 32'h0000_0001);
    check("slave bclk out", 32'(port_bclk_out | port_bclk_oe), 32'h0000_0000);
    check("loop one ticks", near(mt, 560, 16), 32'h0000_0001);
  endtask
  task automatic t_link_loop;
    int mt, st, bt;
    @(posedge clk_sys);
    run_link <= 1'b1;
    port_master_mode <= 3'h4;
    port_rate_code[2] <= `APC_RATE_SECONDARY;
    loop_reference_select[1] <= apc_pkg::APC_REF_LINK_PIN;
    secondary_clock_source_select <= apc_pkg::APC_SRC_LOOP_TWO;
    cycles(400);
    measure(1400, mt, st, bt);
    check("loop two lock", 32'(loop_locked[1]), 32'h0000_0001);
    check("secondary ticks", near(st, 560, 16), 32'h0000_0001);
    check("port three secondary", 32'(port_on_secondary), 32'h0000_0004);
    @(posedge clk_sys);
    run_link <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    cycles(12);
    check("enable in reset", 32'(port_bclk_oe), 32'h0000_0000);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    cycles(4);
    t_rate();
    t_master(4'h1, apc_pkg::APC_SRC_MCLK_ONE, 280);
    t_frame();
    t_master(4'h2, apc_pkg::APC_SRC_MCLK_ONE, 280);
    t_master(4'h1, apc_pkg::APC_SRC_MCLK_TWO, 200);
    t_refuse();
    t_slave_loop();
    t_link_loop();
    complete_run();
  end
  initial begin
    #300000;
    n_mismatch++;
    complete_run();
  end
endmodule
`default_nettype wire

/* File: common/apc_cfg.svh */
// constants for the audio port clock source selection block
`ifndef APC_CFG_SVH
`define APC_CFG_SVH

// ----------------------------------------------------------------
// rate code threshold
// ----------------------------------------------------------------
`define APC_RATE_SECONDARY 4'h8

// ----------------------------------------------------------------
// loop tick ratio, and loop and switch-over timing in clk_sys cycles
// ----------------------------------------------------------------
`define APC_LOOP_RATIO 17'h0_0004
`define APC_PERIOD_MAX 16'hFFFF
`define APC_SWITCH_GUARD 4'h4

// ----------------------------------------------------------------
// serial frame shape
// ----------------------------------------------------------------
`define APC_HALF_FRAME_BITS 6'h20

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define APC_RST_PERIOD 16'h0000
`define APC_RST_DIV 4'h0

`endif

/* File: common/apc_pkg.sv */
// types shared by the audio port clock source selection block
package apc_pkg;

  // system clock source choice
  typedef enum logic [1:0] {
    APC_SRC_MCLK_ONE,
    APC_SRC_MCLK_TWO,
    APC_SRC_LOOP_ONE,
    APC_SRC_LOOP_TWO
  } apc_sys_src_t;

  // loop reference choice
  typedef enum logic [3:0] {
    APC_REF_MCLK_ONE,
    APC_REF_MCLK_TWO,
    APC_REF_BCLK_ONE,
    APC_REF_BCLK_TWO,
    APC_REF_BCLK_THREE,
    APC_REF_LRCLK_ONE,
    APC_REF_LRCLK_TWO,
    APC_REF_LRCLK_THREE,
    APC_REF_LINK_PIN
  } apc_ref_sel_t;

endpackage

/* File: hw/apc_glitch_free_mux.sv */
// glitch-free switch between clock tick streams
`timescale 1ns/1ps
`default_nettype none
`include "apc_cfg.svh"

module apc_glitch_free_mux (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [3:0] tick_in,
  input wire logic [1:0] sel,
  output logic tick_out
);

  typedef enum logic {APC_MUX_RUN, APC_MUX_HOLD} apc_mux_state_t;

  apc_mux_state_t state_reg, state_next;
  logic [1:0] cur_reg, cur_next;
  logic [3:0] guard_reg, guard_next;
  logic tick_reg, tick_next;

  // ----------------------------------------------------------------
  // switch-over sequencing
  // ----------------------------------------------------------------
  // output is silenced for a guard time so no shortened pulse escapes
  always_comb begin
    state_next = state_reg;
    cur_next = cur_reg;
    guard_next = guard_reg;
    tick_next = 1'b0;
    unique case (state_reg)
      APC_MUX_RUN: begin
        if (sel != cur_reg) begin
          state_next = APC_MUX_HOLD;
          guard_next = `APC_SWITCH_GUARD;
        end else begin
          tick_next = tick_in[cur_reg];
        end
      end
      APC_MUX_HOLD: begin
        if (guard_reg == 4'h0) begin
          cur_next = sel;
          state_next = APC_MUX_RUN;
        end else begin
          guard_next = guard_reg - 4'h1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= APC_MUX_RUN;
      cur_reg <= 2'h0;
      guard_reg <= 4'h0;
      tick_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cur_reg <= cur_next;
      guard_reg <= guard_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_out = tick_reg;

endmodule
`default_nettype wire

/* File: hw/apc_port_clockgen.sv */
// bit and frame clock generation for one audio serial port
`timescale 1ns/1ps
`default_nettype none
`include "apc_cfg.svh"

module apc_port_clockgen (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic master,
  input wire logic sys_tick,
  input wire logic [3:0] bclk_div,
  output logic bclk_out,
  output logic bclk_oe,
  output logic lrclk_out,
  output logic lrclk_oe
);

  logic [3:0] tick_cnt_reg, tick_cnt_next;
  logic [5:0] bit_cnt_reg, bit_cnt_next;
  logic bclk_reg, bclk_next;
  logic lrclk_reg, lrclk_next;
  logic oe_reg, oe_next;

  // ----------------------------------------------------------------
  // master clock divider
  // ----------------------------------------------------------------
  // both clocks advance only on system ticks, so they stay locked to it
  always_comb begin
    tick_cnt_next = tick_cnt_reg;
    bit_cnt_next = bit_cnt_reg;
    bclk_next = bclk_reg;
    lrclk_next = lrclk_reg;
    oe_next = master;
    if (!master) begin
      tick_cnt_next = 4'h0;
      bit_cnt_next = 6'h0;
      bclk_next = 1'b0;
      lrclk_next = 1'b0;
    end else if (sys_tick) begin
      if (tick_cnt_reg + 4'h1 >= bclk_div) begin
        tick_cnt_next = 4'h0;
        bclk_next = ~bclk_reg;
        if (bclk_reg) begin
          if (bit_cnt_reg == `APC_HALF_FRAME_BITS - 6'h1) begin
            bit_cnt_next = 6'h0;
            lrclk_next = ~lrclk_reg;
          end else begin
            bit_cnt_next = bit_cnt_reg + 6'h1;
          end
        end
      end else begin
        tick_cnt_next = tick_cnt_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tick_cnt_reg <= 4'h0;
      bit_cnt_reg <= 6'h0;
      bclk_reg <= 1'b0;
      lrclk_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      bit_cnt_reg <= bit_cnt_next;
      bclk_reg <= bclk_next;
      lrclk_reg <= lrclk_next;
      oe_reg <= oe_next;
    end
  end

  assign bclk_out = bclk_reg;
  assign lrclk_out = lrclk_reg;
  assign bclk_oe = oe_reg;
  assign lrclk_oe = oe_reg;

endmodule
`default_nettype wire

/* File: hw/apc_top.sv */
// clock source selection for three audio serial ports
`timescale 1ns/1ps
`default_nettype none
`include "apc_cfg.svh"

module apc_top (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic link_bus_clock_pin,
  input wire logic master_clock_input_one,
  input wire logic master_clock_input_two,
  input wire logic [2:0] port_master_mode,
  input wire logic [2:0][3:0] port_rate_code,
  input wire logic [2:0] port_bclk_in,
  input wire logic [2:0] port_lrclk_in,
  input wire logic [1:0] main_clock_source_select,
  input wire logic [1:0] secondary_clock_source_select,
  input wire logic [1:0][3:0] loop_reference_select,
  input wire logic [3:0] main_clock_frequency_setting,
  input wire logic [3:0] secondary_clock_frequency_setting,
  output logic [2:0] port_bclk_out,
  output logic [2:0] port_bclk_oe,
  output logic [2:0] port_lrclk_out,
  output logic [2:0] port_lrclk_oe,
  output logic [2:0] port_on_secondary,
  output logic main_system_clock_tick,
  output logic secondary_system_clock_tick,
  output logic [1:0] loop_locked,
  output logic [1:0] ratio_valid
);

  // ----------------------------------------------------------------
  // link pin domain
  // ----------------------------------------------------------------
  // the pin may stop; a toggle survives that without a lost or extra event
  logic link_rst_s1_reg, link_rst_s2_reg;
  logic link_tgl_reg, link_tgl_next;

  always_comb begin
    link_tgl_next = ~link_tgl_reg;
  end

  always_ff @(posedge link_bus_clock_pin) begin
    link_rst_s1_reg <= rst_n;
    link_rst_s2_reg <= link_rst_s1_reg;
    if (!link_rst_s2_reg) begin
      link_tgl_reg <= 1'b0;
    end else begin
      link_tgl_reg <= link_tgl_next;
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [8:0] pin_raw;
  logic [8:0] pin_s1_reg, pin_s2_reg, pin_s3_reg;
  logic [8:0] pin_rise;
  logic [8:0] ref_ev;

  assign pin_raw = {link_tgl_reg, port_lrclk_in, port_bclk_in, master_clock_input_two,
                    master_clock_input_one};

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pin_s1_reg <= 9'h000;
      pin_s2_reg <= 9'h000;
      pin_s3_reg <= 9'h000;
    end else begin
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  assign pin_rise = pin_s2_reg & ~pin_s3_reg;

  // link toggle marks an event on either change of its level
  assign ref_ev = {pin_s2_reg[8] ^ pin_s3_reg[8], pin_rise[7:0]};

  // ----------------------------------------------------------------
  // frequency locked loops
  // ----------------------------------------------------------------
  // tick rate is reference rate times the ratio; a period wider than the
  // counter saturates and the loop then reports itself unlocked
  function automatic logic ref_pick(input logic [8:0] ev, input logic [3:0] sel);
    logic hit;
    hit = 1'b0;
    if (sel <= apc_pkg::APC_REF_LINK_PIN) begin
      hit = ev[sel];
    end
    return hit;
  endfunction

  logic [1:0] loop_tick;
  logic [1:0] locked_bits;

  genvar gl;
  generate
    for (gl = 0; gl < 2; gl = gl + 1) begin : g_loop
      logic ref_hit;
      logic [15:0] cnt_reg, cnt_next;
      logic [15:0] period_reg, period_next;
      logic [16:0] acc_reg, acc_next;
      logic tick_reg, tick_next;
      logic lock_reg, lock_next;
      logic [16:0] acc_sum;

      assign ref_hit = ref_pick(ref_ev, loop_reference_select[gl]);

      always_comb begin
        cnt_next = cnt_reg;
        period_next = period_reg;
        lock_next = lock_reg;
        tick_next = 1'b0;
        acc_sum = acc_reg + `APC_LOOP_RATIO;
        acc_next = acc_sum;
        if (ref_hit) begin
          period_next = cnt_reg + 16'h0001;
          cnt_next = 16'h0000;
          lock_next = (period_next == period_reg) && (cnt_reg != `APC_PERIOD_MAX);
        end else if (cnt_reg != `APC_PERIOD_MAX) begin
          cnt_next = cnt_reg + 16'h0001;
        end else begin
          lock_next = 1'b0;
          period_next = `APC_RST_PERIOD;
        end
        if (period_reg == `APC_RST_PERIOD) begin
          acc_next = 17'h0_0000;
        end else if (acc_sum >= {1'b0, period_reg}) begin
          acc_next = acc_sum - {1'b0, period_reg};
          tick_next = 1'b1;
        end
      end

      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          cnt_reg <= 16'h0000;
          period_reg <= `APC_RST_PERIOD;
          acc_reg <= 17'h0_0000;
          tick_reg <= 1'b0;
          lock_reg <= 1'b0;
        end else begin
          cnt_reg <= cnt_next;
          period_reg <= period_next;
          acc_reg <= acc_next;
          tick_reg <= tick_next;
          lock_reg <= lock_next;
        end
      end

      assign loop_tick[gl] = tick_reg;
      assign locked_bits[gl] = lock_reg;
    end
  endgenerate

  // ----------------------------------------------------------------
  // system clock source selection
  // ----------------------------------------------------------------
  logic [3:0] src_ev;
  logic main_tick;
  logic sec_tick;

  assign src_ev = {loop_tick[1], loop_tick[0], pin_rise[1], pin_rise[0]};

  apc_glitch_free_mux u_main_mux (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tick_in(src_ev),
    .sel(main_clock_source_select),
    .tick_out(main_tick)
  );

  apc_glitch_free_mux u_sec_mux (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tick_in(src_ev),
    .sel(secondary_clock_source_select),
    .tick_out(sec_tick)
  );

  // ----------------------------------------------------------------
  // ratio check
  // ----------------------------------------------------------------
  // a zero setting has no integer ratio to the frame and stalls the port
  function automatic logic ratio_ok(input logic [3:0] setting);
    return setting != `APC_RST_DIV;
  endfunction

  logic [1:0] ratio_reg, ratio_next;

  always_comb begin
    ratio_next = {ratio_ok(secondary_clock_frequency_setting),
                  ratio_ok(main_clock_frequency_setting)};
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ratio_reg <= 2'h0;
    end else begin
      ratio_reg <= ratio_next;
    end
  end

  // ----------------------------------------------------------------
  // per-port clocking
  // ----------------------------------------------------------------
  logic [2:0] on_sec_reg, on_sec_next;
  logic [2:0] sys_pick;

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      on_sec_next[i] = port_rate_code[i] >= `APC_RATE_SECONDARY;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      on_sec_reg <= 3'h0;
    end else begin
      on_sec_reg <= on_sec_next;
    end
  end

  genvar gp;
  generate
    for (gp = 0; gp < 3; gp = gp + 1) begin : g_port
      logic [3:0] div;
      logic port_tick;

      // moving a port between system clocks is a source change too
      apc_glitch_free_mux u_port_mux (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .tick_in({2'b00, sec_tick, main_tick}),
        .sel({1'b0, on_sec_reg[gp]}),
        .tick_out(port_tick)
      );

      assign div = on_sec_reg[gp] ? secondary_clock_frequency_setting
                                  : main_clock_frequency_setting;
      // an invalid ratio withholds ticks rather than run at a wrong rate
      assign sys_pick[gp] = port_tick & (on_sec_reg[gp] ? ratio_reg[1] : ratio_reg[0]);

      apc_port_clockgen u_gen (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .master(port_master_mode[gp]),
        .sys_tick(sys_pick[gp]),
        .bclk_div(div),
        .bclk_out(port_bclk_out[gp]),
        .bclk_oe(port_bclk_oe[gp]),
        .lrclk_out(port_lrclk_out[gp]),
        .lrclk_oe(port_lrclk_oe[gp])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // status outputs
  // ----------------------------------------------------------------
  logic main_out_reg, sec_out_reg;
  logic [1:0] locked_out_reg;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      main_out_reg <= 1'b0;
      sec_out_reg <= 1'b0;
      locked_out_reg <= 2'h0;
    end else begin
      main_out_reg <= main_tick;
      sec_out_reg <= sec_tick;
      locked_out_reg <= locked_bits;
    end
  end

  assign main_system_clock_tick = main_out_reg;
  assign secondary_system_clock_tick = sec_out_reg;
  assign loop_locked = locked_out_reg;
  assign ratio_valid = ratio_reg;
  assign port_on_secondary = on_sec_reg;

endmodule
`default_nettype wire
